// ### ivam_map.vh
/*
 * Constants for the interrupt vector address generator: table bases, vector
 * numbering, request numbers of each source and the reset address.
 * Assumes it is included by bare name from the design files of this block.
 */
// Behaviour
// RULE1 - Table-select bit set makes every dispatch use the alternate table.
// RULE2 - Alternate table keeps default layout, placed right after it; only base differs. Code starts it at 0x000104, past a gap at 0x000100-0x000103.
// RULE3 - Reset is no exception; no vector is fetched for it.
// RULE4 - Any reset clears state so execution restarts at address zero.
// RULE5 - Traps 0..7 at 0x000004 or 0x000104, two apart; 1-4 implemented.
// RULE6 - Request n is vector n+8, up to vector 125; unlisted numbers reserved.
// RULE7 - External requests 0, 1, 2 use request numbers 0, 20, 29.
// RULE8 - Timer, capture and compare sources use their fixed request numbers.
// RULE9 - Serial sources use request numbers 9, 10, 11, 12 and 65.
// RULE10 - Converter 13, two-wire target 16, controller 17, pin change 19.
// RULE11 - Among equal user priority, lower vector address wins.
// RULE12 - Each slot is read as a 24-bit entry point for the service routine.
// RULE13 - Vector address is selected base plus twice the vector number.
`ifndef IVAM_MAP_VH
`define IVAM_MAP_VH

`define IVAM_ADDR_W        24
`define IVAM_VEC_W         7
`define IVAM_NUM_VEC       126
`define IVAM_NUM_TRAP      8
`define IVAM_NUM_IRQ       118
`define IVAM_PRIO_W        3
`define IVAM_RESET_ADDR    24'h000000
`define IVAM_DEF_BASE      24'h000004
`define IVAM_ALT_BASE      24'h000104
`define IVAM_IRQ_VEC_OFS   7'h08
`define IVAM_SEL_BIT       15

// Implemented trap vector numbers.
`define IVAM_TRAP_OSC      1
`define IVAM_TRAP_ADDR     2
`define IVAM_TRAP_STACK    3
`define IVAM_TRAP_MATH     4

// Request numbers of the implemented sources.
`define IVAM_IRQ_EXT0      0
`define IVAM_IRQ_CAP1      1
`define IVAM_IRQ_CMP1      2
`define IVAM_IRQ_TMR1      3
`define IVAM_IRQ_CAP2      5
`define IVAM_IRQ_CMP2      6
`define IVAM_IRQ_TMR2      7
`define IVAM_IRQ_TMR3      8
`define IVAM_IRQ_SSP_ERR   9
`define IVAM_IRQ_SSP_DONE  10
`define IVAM_IRQ_UART_RX   11
`define IVAM_IRQ_UART_TX   12
`define IVAM_IRQ_CONV      13
`define IVAM_IRQ_TW_TGT    16
`define IVAM_IRQ_TW_CTL    17
`define IVAM_IRQ_PIN_CHG   19
`define IVAM_IRQ_EXT1      20
`define IVAM_IRQ_CAP7      22
`define IVAM_IRQ_CAP8      23
`define IVAM_IRQ_EXT2      29
`define IVAM_IRQ_UART_ERR  65

`endif

// ### ivam_vec_addr.v
/*
 * Combinational vector address former: table base chosen by the select bit
 * plus twice the vector number.
 * Assumes a vector number below the table size; the caller registers the result.
 */
`default_nettype none
`include "ivam_map.vh"

module ivam_vec_addr (
	input  wire                       alt_table_select,
	input  wire [`IVAM_VEC_W-1:0]     vec_num,
	output wire [`IVAM_ADDR_W-1:0]    vec_addr
);

	// Both tables share one layout, so only the base moves with the select bit.
	wire [`IVAM_ADDR_W-1:0] base;
	assign base     = alt_table_select ? `IVAM_ALT_BASE : `IVAM_DEF_BASE; // RULE1 RULE2
	assign vec_addr = base + {{(`IVAM_ADDR_W-`IVAM_VEC_W-1){1'b0}}, vec_num, 1'b0}; // RULE13

endmodule // ivam_vec_addr
`default_nettype wire

// ### ivam_vector_unit.v
/*
 * Vector dispatch for the interrupt controller. Picks the winning trap or
 * request, forms the program-memory word address of its vector slot and
 * offers it to the core with a valid held until vec_ack; the core then loads the
 * 24-bit slot contents as the entry point.
 * Assumes the core, flag, enable and priority logic sit outside; requests
 * arrive already enabled with their user priority, synchronous to clk.
 */
`default_nettype none
`include "ivam_map.vh"

module ivam_vector_unit (
	input  wire                                      clk,
	input  wire                                      rst_n,
	input  wire                                      clk_en,
	input  wire [15:0]                               interrupt_control_second,
	input  wire [`IVAM_NUM_TRAP-1:0]                 trap_req,
	input  wire [`IVAM_NUM_IRQ-1:0]                  irq_req,
	input  wire [`IVAM_NUM_IRQ*`IVAM_PRIO_W-1:0]     irq_prio,
	input  wire [`IVAM_PRIO_W-1:0]                   cpu_prio,
	input  wire                                      vec_ack,
	output reg                                       vec_valid_r,
	output reg  [`IVAM_VEC_W-1:0]                    vec_num_r,
	output reg  [`IVAM_ADDR_W-1:0]                   vec_addr_r,
	output reg                                       alt_active_r,
	output reg  [`IVAM_ADDR_W-1:0]                   pc_start_r
);

	localparam ST_IDLE = 1'b0;
	localparam ST_WAIT = 1'b1;

	// Reserved request slots never raise a request.
	localparam [`IVAM_NUM_IRQ-1:0] IRQ_IMPL =
		(118'h1 << `IVAM_IRQ_EXT0)     | (118'h1 << `IVAM_IRQ_CAP1)     | // RULE7 RULE8
		(118'h1 << `IVAM_IRQ_CMP1)     | (118'h1 << `IVAM_IRQ_TMR1)     | // RULE8
		(118'h1 << `IVAM_IRQ_CAP2)     | (118'h1 << `IVAM_IRQ_CMP2)     | // RULE8
		(118'h1 << `IVAM_IRQ_TMR2)     | (118'h1 << `IVAM_IRQ_TMR3)     | // RULE8
		(118'h1 << `IVAM_IRQ_SSP_ERR)  | (118'h1 << `IVAM_IRQ_SSP_DONE) | // RULE9
		(118'h1 << `IVAM_IRQ_UART_RX)  | (118'h1 << `IVAM_IRQ_UART_TX)  | // RULE9
		(118'h1 << `IVAM_IRQ_CONV)     | (118'h1 << `IVAM_IRQ_TW_TGT)   | // RULE10
		(118'h1 << `IVAM_IRQ_TW_CTL)   | (118'h1 << `IVAM_IRQ_PIN_CHG)  | // RULE10
		(118'h1 << `IVAM_IRQ_EXT1)     | (118'h1 << `IVAM_IRQ_CAP7)     | // RULE7 RULE8
		(118'h1 << `IVAM_IRQ_CAP8)     | (118'h1 << `IVAM_IRQ_EXT2)     | // RULE8 RULE7
		(118'h1 << `IVAM_IRQ_UART_ERR);                                   // RULE9 RULE6

	localparam [`IVAM_NUM_TRAP-1:0] TRAP_IMPL =
		(8'h1 << `IVAM_TRAP_OSC) | (8'h1 << `IVAM_TRAP_ADDR) |
		(8'h1 << `IVAM_TRAP_STACK) | (8'h1 << `IVAM_TRAP_MATH); // RULE5

	reg                      state_r;
	reg                      found;
	reg  [`IVAM_VEC_W-1:0]   win_vec;
	reg  [`IVAM_PRIO_W-1:0]  best_prio;
	wire [`IVAM_NUM_IRQ-1:0] irq_live;
	wire [`IVAM_NUM_TRAP-1:0] trap_live;
	wire                     sel_alt;
	wire [`IVAM_ADDR_W-1:0]  slot_addr;
	integer                  i;

	assign sel_alt   = interrupt_control_second[`IVAM_SEL_BIT]; // RULE1
	assign trap_live = trap_req & TRAP_IMPL;

	// A request competes only when its priority is above the core's level.
	genvar g;
	generate
		for (g = 0; g < `IVAM_NUM_IRQ; g = g + 1) begin : g_live
			assign irq_live[g] = irq_req[g] & IRQ_IMPL[g] &
				(irq_prio[g*`IVAM_PRIO_W +: `IVAM_PRIO_W] > cpu_prio);
		end
	endgenerate

	// Traps beat every request, the lowest trap vector first. Among requests the
	// highest user priority wins; scanning from the top with >= leaves the lowest
	// vector among equals, which keeps the natural order without a second pass.
	always @* begin
		found     = 1'b0;
		win_vec   = {`IVAM_VEC_W{1'b0}};
		best_prio = {`IVAM_PRIO_W{1'b0}};
		for (i = `IVAM_NUM_IRQ - 1; i >= 0; i = i - 1) begin
			if (irq_live[i] &&
			    (!found || irq_prio[i*`IVAM_PRIO_W +: `IVAM_PRIO_W] >= best_prio)) begin // RULE11
				found     = 1'b1;
				best_prio = irq_prio[i*`IVAM_PRIO_W +: `IVAM_PRIO_W];
				win_vec   = i[`IVAM_VEC_W-1:0] + `IVAM_IRQ_VEC_OFS; // RULE6
			end
		end
		for (i = `IVAM_NUM_TRAP - 1; i >= 0; i = i - 1) begin
			if (trap_live[i]) begin
				found   = 1'b1;
				win_vec = i[`IVAM_VEC_W-1:0]; // RULE5 RULE11
			end
		end
	end

	ivam_vec_addr u_addr (
		.alt_table_select (sel_alt),
		.vec_num          (win_vec),
		.vec_addr         (slot_addr)
	);

	// Reset sets the start address straight to zero; no vector slot is involved.
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_r      <= ST_IDLE;
			vec_valid_r  <= 1'b0;
			vec_num_r    <= {`IVAM_VEC_W{1'b0}};
			vec_addr_r   <= {`IVAM_ADDR_W{1'b0}};
			alt_active_r <= 1'b0;
			pc_start_r   <= `IVAM_RESET_ADDR; // RULE3 RULE4
		end else if (clk_en) begin
			alt_active_r <= sel_alt; // RULE1
			case (state_r)
				ST_IDLE: begin
					if (found) begin
						vec_valid_r <= 1'b1;
						vec_num_r   <= win_vec;
						vec_addr_r  <= slot_addr; // RULE12 RULE13
						state_r     <= ST_WAIT;
					end
				end
				ST_WAIT: begin
					// The offer holds steady until the core takes it.
					if (vec_ack) begin
						vec_valid_r <= 1'b0;
						state_r     <= ST_IDLE;
					end
				end
				default: begin
					vec_valid_r <= 1'b0;
					state_r     <= ST_IDLE;
				end
			endcase
		end
	end

endmodule // ivam_vector_unit
`default_nettype wire

// ### ivam_asserts.sv
/* Checker for the vector unit ports. Assumes the bind below. */
`default_nettype none
module ivam_asserts (
	input wire logic         clk,
	input wire logic         rst_n,
	input wire logic         clk_en,
	input wire logic [15:0]  interrupt_control_second,
	input wire logic [7:0]   trap_req,
	input wire logic [117:0] irq_req,
	input wire logic         vec_ack,
	input wire logic         vec_valid_r,
	input wire logic [6:0]   vec_num_r,
	input wire logic [23:0]  vec_addr_r,
	input wire logic         alt_active_r,
	input wire logic [23:0]  pc_start_r
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	// Base is fixed by the select bit at the take edge, not by the late copy.
	property p_addr;
		$rose(vec_valid_r) |-> vec_addr_r == ($past(interrupt_control_second[15]) ?
			24'h000104 : 24'h000004) + {vec_num_r, 1'b0};
	endproperty
	a_addr: assert property (p_addr) else $error("vector address wrong");
	property p_stand;
		vec_valid_r && !(vec_ack && clk_en) |=> vec_valid_r && $stable(vec_addr_r);
	endproperty
	a_stand: assert property (p_stand) else $error("offer dropped early");
	property p_pc;
		pc_start_r == 24'h000000;
	endproperty
	a_pc: assert property (p_pc) else $error("start address not zero");
	property p_gap;
		vec_valid_r && vec_ack && clk_en |=> !vec_valid_r;
	endproperty
	a_gap: assert property (p_gap) else $error("offer held after ack");
	property p_trap;
		!vec_valid_r && clk_en && trap_req[1] |=> vec_valid_r ##0 vec_num_r == 7'h01;
	endproperty
	a_trap: assert property (p_trap) else $error("first trap not chosen");
	property p_idle;
		!vec_valid_r && clk_en && irq_req == '0 && trap_req[4:1] == 4'h0 |=> !vec_valid_r;
	endproperty
	a_idle: assert property (p_idle) else $error("offer without source");
	property p_range;
		vec_valid_r |-> vec_num_r != 7'h00 && vec_num_r <= 7'h7D;
	endproperty
	a_range: assert property (p_range) else $error("vector out of range");
	property p_copy;
		$past(rst_n) && $past(clk_en) |-> alt_active_r == $past(interrupt_control_second[15]);
	endproperty
	a_copy: assert property (p_copy) else $error("select copy stale");
endmodule // ivam_asserts
bind ivam_vector_unit ivam_asserts u_chk (.clk(clk), .rst_n(rst_n), .clk_en(clk_en),
	.interrupt_control_second(interrupt_control_second), .trap_req(trap_req),
	.irq_req(irq_req), .vec_ack(vec_ack), .vec_valid_r(vec_valid_r), .vec_num_r(vec_num_r),
	.vec_addr_r(vec_addr_r), .alt_active_r(alt_active_r), .pc_start_r(pc_start_r));
`default_nettype wire

// ### ivam_core_model.sv
/* Core model that takes vector offers. Assumes the bench picks the ack delay. */
`default_nettype none
module ivam_core_model (
	input  wire logic       clk,
	input  wire logic       vec_valid_r,
	input  wire logic [3:0] delay,
	output var  logic       vec_ack
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0] cnt = 4'h0;
	initial vec_ack = 1'b0;
	// A slow core stalls so the offer must stand; ack is a single cycle.
	always @(posedge clk) begin
		vec_ack <= vec_valid_r && !vec_ack && cnt >= delay;
		cnt <= (vec_valid_r && !vec_ack) ? cnt + 4'h1 : 4'h0;
	end
endmodule // ivam_core_model
`default_nettype wire

// ### interrupt_vector_address_map_test.sv
/* Bench for the vector unit. Assumes the checker is bound to it. */
`default_nettype none
module interrupt_vector_address_map_test;
	timeunit 1ns;
	timeprecision 1ps;
	logic         clk = 1'b0;
	logic         rst_n = 1'b0;
	logic [15:0]  ics = 16'h0000;
	logic [7:0]   trap_req = 8'h00;
	logic [117:0] irq_req = '0;
	logic [3:0]   slow = 4'h0;
	logic         en = 1'b1;
	logic [353:0] prio = {118{3'h1}};
	logic [2:0]   cpu = 3'h0;
	logic         alt_active_r;
	logic         vec_ack, vec_valid_r;
	logic [6:0]   vec_num_r;
	logic [23:0]  vec_addr_r, pc_start_r;
	int           error_cnt = 0;
	int           n_tests = 0;
	int           tbl[21] = '{0, 1, 2, 3, 5, 6, 7, 8, 9, 10, 11, 12, 13, 16, 17, 19, 20, 22, 23, 29, 65};
	ivam_vector_unit dut (.clk(clk), .rst_n(rst_n), .clk_en(en), .interrupt_control_second(ics),
		.trap_req(trap_req), .irq_req(irq_req), .irq_prio(prio), .cpu_prio(cpu),
		.vec_ack(vec_ack), .vec_valid_r(vec_valid_r), .vec_num_r(vec_num_r),
		.vec_addr_r(vec_addr_r), .alt_active_r(alt_active_r), .pc_start_r(pc_start_r));
	ivam_core_model core (.clk(clk), .vec_valid_r(vec_valid_r), .delay(slow), .vec_ack(vec_ack));
	initial forever #10 clk = ~clk;
	task automatic conclude();
		$display("tests %0d errors %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
		n_tests++;
		if (got !== exp) begin
			error_cnt++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask
	// Raise sources, expect vector v (none if negative), then let the core take it.
	task automatic run(input logic [7:0] t, input logic [117:0] r, input logic alt, input int v);
		int i;
		@(negedge clk);
		trap_req = t;
		irq_req = r;
		ics = {alt, 15'h0000};
		for (i = 0; i < 8 && vec_valid_r !== 1'b1; i++) @(negedge clk);
		trap_req = 8'h00;
		irq_req = '0;
		chk("offer", {23'h0, v >= 0}, {23'h0, vec_valid_r});
		if (v >= 0) begin
			chk("num", 24'(v), {17'h0, vec_num_r});
			chk("addr", (alt ? 24'h000104 : 24'h000004) + 24'(2 * v), vec_addr_r);
			chk("alt", {23'h0, alt}, {23'h0, alt_active_r});
		end
		for (i = 0; i < 12 && vec_valid_r !== 1'b0; i++) @(negedge clk);
		if (i == 12) begin
			error_cnt++;
			conclude();
		end
	endtask
	task automatic t_table();
		for (int a = 0; a < 2; a++)
			foreach (tbl[k]) run(8'h00, 118'h1 << tbl[k], a[0], tbl[k] + 8);
	endtask
	task automatic t_traps();
		slow = 4'h5;
		for (int k = 1; k < 9; k++) run(8'h01 << (k % 5 + k / 5), '0, k > 4, k % 5 + k / 5);
		run(8'hE1, '0, 1'b1, -1);
		slow = 4'h0;
	endtask
	task automatic t_prio();
		run(8'h00, (118'h1 << 3) | (118'h1 << 20), 1'b1, 11);
		run(8'h04, 118'h1, 1'b0, 2);
		run(8'h00, (118'h1 << 4) | (118'h1 << 14), 1'b0, -1);
		// A higher user priority beats a lower request number.
		prio[62:60] = 3'h3;
		run(8'h00, (118'h1 << 3) | (118'h1 << 20), 1'b0, 28);
		prio[62:60] = 3'h1;
		// Requests at or below the core level stay out; traps ignore the level.
		cpu = 3'h1;
		run(8'h00, 118'h1 << 3, 1'b0, -1);
		cpu = 3'h7;
		run(8'h02, 118'h1 << 3, 1'b0, 1);
		cpu = 3'h0;
	endtask
	// With the clock enable low no offer may appear while a request stands for eight cycles.
	task automatic t_frz();
		en = 1'b0;
		run(8'h00, 118'h1 << 3, 1'b0, -1);
		en = 1'b1;
	endtask
	// A reset in the middle of a standing offer clears it at once and fetches nothing.
	task automatic t_rst();
		slow = 4'h5;
		@(negedge clk);
		irq_req = 118'h1 << 3;
		@(negedge clk);
		chk("offer up", 24'h000001, {23'h0, vec_valid_r});
		rst_n = 1'b0;
		irq_req = '0;
		#1;
		chk("rst valid", 24'h000000, {23'h0, vec_valid_r});
		chk("rst addr", 24'h000000, vec_addr_r);
		chk("rst pc", 24'h000000, pc_start_r);
		repeat (2) @(negedge clk);
		rst_n = 1'b1;
		repeat (2) @(negedge clk);
		chk("post valid", 24'h000000, {23'h0, vec_valid_r});
		slow = 4'h0;
	endtask
	initial begin
		repeat (20) @(negedge clk);
		rst_n = 1'b1;
		chk("pc", 24'h000000, pc_start_r);
		chk("idle", 24'h000000, {23'h0, vec_valid_r});
		t_table();
		t_traps();
		t_prio();
		t_frz();
		t_rst();
		conclude();
	end
endmodule // interrupt_vector_address_map_test
`default_nettype wire
